// ==== verilog/ascp_port.sv ====
`timescale 1ns/100ps
`include "ascp_params.svh"

// Overview of operation
// - host sends a 4-bit command word, msb first, choosing input or rate/power.
// - processor mode: capture four bits on rising clock edges, falling if inverted.
// - signal-processor mode: capture four bits on falling edges, rising if inverted.
// - after four command bits serial input is ignored for the period.
// - serial output floats while select is high, driven otherwise.
// - leading result bit is driven at frame start before any shift.
// - output updates on falling edges processor mode, rising edges signal mode.
// - done flag falls on tenth hand-off edge (processor rising, signal falling) and stays low until result ready.
// - processor mode sampling from fourth falling edge to tenth rising edge.
// - processor mode shifts result on first ten falling edges, any edge select.
// - processor mode hands conversion to core on tenth rising edge.
// - signal mode sampling from fourth rising edge to tenth falling edge.
// - extended sampling window follows the low time of sample start.
// - signal mode: leading bit after frame sync falls, rest on rising edges.
// - signal mode hands conversion to core on tenth falling edge.
// - host mode flag latched from frame sync at select falling edge.
// - select fall resets counters and enables port, in signal mode only once frame sync falls; rise disables it.
// - processor mode drives output low from the tenth falling edge.
module ascp_port (
   input  wire logic                   clk_i,
   input  wire logic                   nrst_i,
   input  wire logic                   chip_select_n_i,
   input  wire logic                   frame_sync_i,
   input  wire logic                   serial_clock_i,
   input  wire logic                   serial_in_i,
   input  wire logic                   edge_select_n_i,
   input  wire logic                   sample_start_n_i,
   input  wire logic                   conv_done_i,
   input  wire logic [`ASCP_RES_W-1:0] conv_result_i,
   output logic                        serial_out_o,
   output logic                        serial_out_oe_n_o,
   output logic                        conversion_done_flag_o,
   output logic [`ASCP_CMD_W-1:0]      command_o,
   output logic                        command_valid_o,
   output logic                        sampling_o,
   output logic                        conv_start_o,
   output logic                        processor_mode_o
);
   ////////////////////////////////////////////////////////////////////////////
   // synchronised pins
   logic cs_s, cs_p, fs_s, fs_p, sck_s, sck_p, din_s, es_s, ss_s, ss_p;

   // select, frame sync, edge select and sample start idle high
   ascp_sync #(.IDLE_LVL(1'b1)) u_cs (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(chip_select_n_i),
      .q_o(cs_s), .q_prev_o(cs_p));
   ascp_sync #(.IDLE_LVL(1'b1)) u_fs (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(frame_sync_i),
      .q_o(fs_s), .q_prev_o(fs_p));
   ascp_sync #(.IDLE_LVL(1'b0)) u_sck (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(serial_clock_i),
      .q_o(sck_s), .q_prev_o(sck_p));
   ascp_sync #(.IDLE_LVL(1'b0)) u_din (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(serial_in_i),
      .q_o(din_s), .q_prev_o());
   ascp_sync #(.IDLE_LVL(1'b1)) u_es (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(edge_select_n_i),
      .q_o(es_s), .q_prev_o());
   ascp_sync #(.IDLE_LVL(1'b1)) u_ss (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(sample_start_n_i),
      .q_o(ss_s), .q_prev_o(ss_p));

   ////////////////////////////////////////////////////////////////////////////
   // decode
   ascp_pkg::ascp_state_t       state_r, state_nxt;
   logic                        pmode_r, armed_r, done_r, samp_r, start_r, so_r, oe_n_r, cmdv_r, ext_r;
   logic [`ASCP_CNT_W-1:0]      cap_cnt_r, rise_cnt_r, fall_cnt_r;
   logic [`ASCP_CMD_W-1:0]      cmd_r;
   logic [`ASCP_RES_W-1:0]      hold_r, shift_r;

   wire cs_fall  = cs_p & ~cs_s;
   wire cs_rise  = ~cs_p & cs_s;
   wire fs_fall  = fs_p & ~fs_s;
   wire sck_rise = ~sck_p & sck_s;
   wire sck_fall = sck_p & ~sck_s;
   wire ss_fall  = ss_p & ~ss_s;
   wire ss_rise  = ~ss_p & ss_s;
   wire active   = (state_r == ascp_pkg::ASCP_FRAME) & armed_r;
   // shifting and edge counting go on after hand-off: the tenth processor fall comes after the tenth rise
   wire live     = (state_r != ascp_pkg::ASCP_IDLE) & armed_r;
   // capture edge: processor rising, signal falling; edge select low swaps it
   wire cap_edge = (pmode_r ~^ es_s) ? sck_rise : sck_fall;
   wire out_edge = pmode_r ? sck_fall : sck_rise;
   wire hand_edge = pmode_r ? sck_rise : sck_fall;
   wire samp_edge = pmode_r ? sck_fall : sck_rise;
   wire [`ASCP_CNT_W-1:0] hand_cnt = pmode_r ? rise_cnt_r : fall_cnt_r;
   wire [`ASCP_CNT_W-1:0] samp_cnt = pmode_r ? fall_cnt_r : rise_cnt_r;
   wire [`ASCP_CNT_W-1:0] out_cnt  = pmode_r ? fall_cnt_r : rise_cnt_r;
   wire take_bit  = active & cap_edge & (cap_cnt_r < `ASCP_CMD_EDGES);
   wire hand_now  = active & hand_edge & (hand_cnt == `ASCP_LAST_EDGE - 5'h01);
   wire samp_now  = active & samp_edge & (samp_cnt == `ASCP_CMD_EDGES - 5'h01);
   wire shift_now = live & out_edge & (out_cnt < `ASCP_LAST_EDGE);
   // a signal-processor frame opens only after frame sync falls
   wire arm_now   = (state_r == ascp_pkg::ASCP_FRAME) & ~armed_r & ~pmode_r & fs_fall;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ascp_pkg::ASCP_IDLE:   if (cs_fall) state_nxt = ascp_pkg::ASCP_FRAME;
         ascp_pkg::ASCP_FRAME:  if (cs_rise) state_nxt = ascp_pkg::ASCP_IDLE;
                                else if (hand_now) state_nxt = ascp_pkg::ASCP_HANDED;
         ascp_pkg::ASCP_HANDED: if (cs_rise) state_nxt = ascp_pkg::ASCP_IDLE;
         default:               state_nxt = ascp_pkg::ASCP_IDLE;
      endcase
      if (cs_fall) state_nxt = ascp_pkg::ASCP_FRAME;
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame control
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_r <= ascp_pkg::ASCP_IDLE;
         pmode_r <= 1'b1;
         armed_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (cs_fall) pmode_r <= fs_s;
         if (cs_fall) armed_r <= fs_s;
         else if (arm_now) armed_r <= 1'b1;
         else if (cs_rise) armed_r <= 1'b0;
      end
   end

   // edge counters restart with every select fall or signal-mode frame start
   always_ff @(posedge clk_i) begin
      if (!nrst_i || cs_fall || arm_now) begin
         cap_cnt_r  <= 5'h00;
         rise_cnt_r <= 5'h00;
         fall_cnt_r <= 5'h00;
      end else if (live) begin
         if (cap_edge && cap_cnt_r != 5'h1F) cap_cnt_r <= cap_cnt_r + 5'h01;
         if (sck_rise && rise_cnt_r != 5'h1F) rise_cnt_r <= rise_cnt_r + 5'h01;
         if (sck_fall && fall_cnt_r != 5'h1F) fall_cnt_r <= fall_cnt_r + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command in, msb first, passed as an opaque field
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cmd_r  <= `ASCP_CMD_RST;
         cmdv_r <= 1'b0;
      end else begin
         if (cs_fall) cmdv_r <= 1'b0;
         if (take_bit) cmd_r <= {cmd_r[`ASCP_CMD_W-2:0], din_s};
         if (take_bit && cap_cnt_r == `ASCP_CMD_EDGES - 5'h01) cmdv_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sampling window and hand-off; extended sampling tracks sample start low time
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         samp_r  <= 1'b0;
         start_r <= 1'b0;
         ext_r   <= 1'b0;
      end else begin
         start_r <= 1'b0;
         if (ss_fall) begin
            ext_r  <= 1'b1;
            samp_r <= 1'b1;
         end else if (ss_rise && ext_r) begin
            ext_r   <= 1'b0;
            samp_r  <= 1'b0;
            start_r <= 1'b1;
         end else if (samp_now) begin
            samp_r <= 1'b1;
         end else if (hand_now) begin
            if (!ext_r) samp_r <= 1'b0;
            start_r <= ~ext_r;
         end else if (cs_fall && !ext_r) begin
            samp_r <= 1'b0;
         end
      end
   end

   // busy from hand-off until the core reports completion; hand-off beats completion
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         done_r <= 1'b1;
         hold_r <= `ASCP_RES_RST;
      end else begin
         if (hand_now || (ss_rise && ext_r)) done_r <= 1'b0;
         else if (conv_done_i) done_r <= 1'b1;
         if (conv_done_i && !done_r) hold_r <= conv_result_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // result out
   wire drive_on = (state_r != ascp_pkg::ASCP_IDLE);
   wire [`ASCP_RES_W-1:0] shift_nxt = {shift_r[`ASCP_RES_W-2:0], 1'b0};

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         shift_r <= `ASCP_RES_RST;
         so_r    <= 1'b0;
         oe_n_r  <= 1'b1;
      end else begin
         oe_n_r <= ~drive_on | cs_rise;
         if (cs_fall || arm_now) begin
            shift_r <= hold_r;
            so_r    <= hold_r[`ASCP_RES_W-1];
         end else if (shift_now) begin
            shift_r <= shift_nxt;
            // trailing zeros after the tenth edge for long frames
            so_r    <= (out_cnt == `ASCP_LAST_EDGE - 5'h01) ? 1'b0 : shift_nxt[`ASCP_RES_W-1];
         end
      end
   end

   assign serial_out_o           = so_r;
   assign serial_out_oe_n_o      = oe_n_r;
   assign conversion_done_flag_o = done_r;
   assign command_o              = cmd_r;
   assign command_valid_o        = cmdv_r;
   assign sampling_o             = samp_r;
   assign conv_start_o           = start_r;
   assign processor_mode_o       = pmode_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   chk_oe_idle_float: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (state_r == ascp_pkg::ASCP_IDLE) |=> serial_out_oe_n_o) else $error("output driven while idle");
   chk_done_falls_hand: assert property (@(posedge clk_i) disable iff (!nrst_i)
      hand_now |=> !conversion_done_flag_o) else $error("done flag did not fall at hand-off");
   chk_start_pulse: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (hand_now && !ext_r && !ss_fall && !ss_rise) |=> conv_start_o ##1 !conv_start_o)
      else $error("conversion start pulse wrong");
   chk_cmd_frozen: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (cmdv_r && !cs_fall) |=> $stable(cmd_r)) else $error("command changed after four bits");
   chk_mode_latch: assert property (@(posedge clk_i) disable iff (!nrst_i)
      cs_fall |=> (processor_mode_o == $past(fs_s))) else $error("mode flag not latched");
   chk_msb_first: assert property (@(posedge clk_i) disable iff (!nrst_i)
      cs_fall |=> (serial_out_o == $past(hold_r[`ASCP_RES_W-1]))) else $error("leading bit missing");
   chk_tail_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (live && out_cnt >= `ASCP_LAST_EDGE && !cs_fall && !arm_now) |=> !serial_out_o)
      else $error("output not zero after tenth edge");
   chk_sample_open: assert property (@(posedge clk_i) disable iff (!nrst_i)
      samp_now |=> sampling_o [*2]) else $error("sampling did not open");
   chk_counter_reset: assert property (@(posedge clk_i) disable iff (!nrst_i)
      cs_fall |=> (cap_cnt_r == 5'h00 && rise_cnt_r == 5'h00)) else $error("counters not reset");

   cov_proc_hand: cover property (@(posedge clk_i) disable iff (!nrst_i) hand_now && pmode_r);
   cov_dsp_hand:  cover property (@(posedge clk_i) disable iff (!nrst_i) hand_now && !pmode_r);
   cov_ext_samp:  cover property (@(posedge clk_i) disable iff (!nrst_i) ss_rise && ext_r);
   cov_done_back: cover property (@(posedge clk_i) disable iff (!nrst_i) !done_r ##1 done_r);
endmodule : ascp_port

// ==== shared/ascp_params.svh ====
`ifndef ASCP_PARAMS_SVH
`define ASCP_PARAMS_SVH
`define ASCP_CMD_W      4
`define ASCP_RES_W      10
`define ASCP_CNT_W      5
`define ASCP_CMD_EDGES  5'h04
`define ASCP_LAST_EDGE  5'h0A
`define ASCP_RES_RST    10'h000
`define ASCP_CMD_RST    4'h0
`endif

// ==== shared/ascp_pkg.sv ====
package ascp_pkg;
   typedef enum logic [1:0] {
      ASCP_IDLE   = 2'b00,
      ASCP_FRAME  = 2'b01,
      ASCP_HANDED = 2'b10
   } ascp_state_t;
endpackage : ascp_pkg

// ==== verilog/ascp_sync.sv ====
`timescale 1ns/100ps
// two-flop synchroniser plus a registered copy so edges are found on flop outputs only
// flops reset to the pin's idle level so reset release never looks like an edge
module ascp_sync #(
   parameter logic IDLE_LVL = 1'b0
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic d_i,
   output logic      q_o,
   output logic      q_prev_o
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         meta_r <= IDLE_LVL;
         sync_r <= IDLE_LVL;
         prev_r <= IDLE_LVL;
      end else begin
         meta_r <= d_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign q_o      = sync_r;
   assign q_prev_o = prev_r;
endmodule : ascp_sync

// ==== verification/ascp_host.sv ====
`timescale 1ns/100ps
// host serial port model: serial clock idles low and runs only inside a frame
module ascp_host (
   input  wire logic clk_i,
   input  wire logic sdo_i,
   input  wire logic oe_n_i,
   output logic      cs_n_o,
   output logic      fs_o,
   output logic      sclk_o,
   output logic      sdi_o
);
   initial begin
      cs_n_o = 1'b1;
      fs_o   = 1'b1;
      sclk_o = 1'b0;
      sdi_o  = 1'b0;
   end

   task automatic step(input int n);
      repeat (n) @(negedge clk_i);
   endtask : step

   ////////////////////////////////////////
   // 12 clock cycles of 64 ns; reads the line just before each edge that may move it
   task automatic xfer(input logic dsp, input logic [3:0] cmd, output logic [11:0] rx, output logic oe_n);
      fs_o = ~dsp;
      step(8);
      cs_n_o = 1'b0;
      step(8);
      if (dsp) begin
         fs_o = 1'b1;
         step(8);
         fs_o = 1'b0;
      end
      sdi_o = cmd[3];
      step(8);
      oe_n = oe_n_i;
      for (int i = 0; i < 12; i++) begin
         if (dsp) rx[11-i] = sdo_i;
         sclk_o = 1'b1;
         step(8);
         if (!dsp) rx[11-i] = sdo_i;
         sclk_o = 1'b0;
         // data moves mid-low-phase so either capture edge sees it settled
         step(4);
         sdi_o = (i < 3) ? cmd[2-i] : ~sdi_o;
         step(4);
      end
      cs_n_o = 1'b1;
      fs_o   = 1'b1;
      step(8);
   endtask : xfer
endmodule : ascp_host

// ==== verification/ascp_port_tb.sv ====
`timescale 1ns/100ps
`include "ascp_params.svh"
module ascp_port_tb;
   logic       clk_i, nrst_i, cs_n, fs, sclk, sdi, esn, ssn, cdone;
   logic [9:0] cres;
   logic       sdo, oe_n, done_f, cvalid, samp, sample_start_n, pmode;
   int         n_samp = 0;
   logic [3:0] cmd;
   int         err_total = 0;
   int         n_tests = 0;
   int         n_conv = 0;
   logic [3:0] cmd_tab [4] = '{4'hA, 4'h5, 4'h3, 4'hC};
   logic [9:0] res_tab [4] = '{10'h2B5, 10'h14A, 10'h0F0, 10'h201};
   // a released line shows the inverse, so a stale level never passes
   wire        sdo_line = oe_n ? ~sdo : sdo;

   ascp_port u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .chip_select_n_i(cs_n), .frame_sync_i(fs),
      .serial_clock_i(sclk), .serial_in_i(sdi), .edge_select_n_i(esn), .sample_start_n_i(ssn),
      .conv_done_i(cdone), .conv_result_i(cres), .serial_out_o(sdo), .serial_out_oe_n_o(oe_n),
      .conversion_done_flag_o(done_f), .command_o(cmd), .command_valid_o(cvalid),
      .sampling_o(samp), .conv_start_o(sample_start_n), .processor_mode_o(pmode));

   ascp_host u_host (.clk_i(clk_i), .sdo_i(sdo_line), .oe_n_i(oe_n), .cs_n_o(cs_n), .fs_o(fs),
      .sclk_o(sclk), .sdi_o(sdi));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      if (sample_start_n === 1'b1) n_conv <= n_conv + 1;
      if (samp === 1'b1) n_samp <= n_samp + 1;
   end

   ////////////////////////////////////////
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic end_of_test;
      if (err_total == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   initial begin
      #100000;
      err_total++;
      end_of_test();
   end

   ////////////////////////////////////////
   initial begin
      logic [11:0] rx;
      logic        oe, dsp;
      logic [9:0]  prev;
      int          n0;
      int          s0;
      nrst_i = 1'b0;
      esn    = 1'b1;
      ssn    = 1'b1;
      cdone  = 1'b0;
      cres   = 10'h000;
      prev   = `ASCP_RES_RST;
      repeat (6) @(negedge clk_i);
      nrst_i = 1'b1;
      repeat (4) @(negedge clk_i);
      chk("oe_n idle", 12'h001, oe_n);
      chk("done idle", 12'h001, done_f);
      chk("command reset", `ASCP_CMD_RST, cmd);
      chk("mode reset", 12'h001, pmode);
      // both modes, both clock senses; bits after the fourth toggle to prove they are ignored
      for (int k = 0; k < 4; k++) begin
         dsp = k[1];
         esn = ~k[0];
         s0 = n_samp;
         n0 = n_conv;
         u_host.xfer(dsp, cmd_tab[k], rx, oe);
         chk("oe_n in frame", 12'h000, oe);
         chk("oe_n after frame", 12'h001, oe_n);
         chk("result bits", {prev, 2'b00}, rx);
         chk("command", cmd_tab[k], cmd);
         chk("command valid", 12'h001, cvalid);
         chk("mode", {11'h000, ~dsp}, pmode);
         chk("busy after tenth", 12'h000, done_f);
         chk("conversion starts", 12'(n0 + 1), 12'(n_conv));
         chk("sampling seen", 12'h001, {11'h000, n_samp > s0});
         chk("sampling closed", 12'h000, samp);
         prev  = res_tab[k];
         cres  = prev;
         cdone = 1'b1;
         @(negedge clk_i);
         cdone = 1'b0;
         repeat (4) @(negedge clk_i);
         chk("done after result", 12'h001, done_f);
      end
      n0  = n_conv;
      ssn = 1'b0;
      repeat (8) @(negedge clk_i);
      chk("extended window open", 12'h001, samp);
      ssn = 1'b1;
      repeat (8) @(negedge clk_i);
      chk("extended window closed", 12'h000, samp);
      chk("extended start", 12'(n0 + 1), 12'(n_conv));
      chk("extended busy", 12'h000, done_f);
      end_of_test();
   end
endmodule : ascp_port_tb
